// ==== src/mmd_regs.vh ====
// Constants for the memory map and bank decoder.
// Assumes inclusion by bare name from the design files.
`ifndef MMD_REGS_VH
`define MMD_REGS_VH
// ****************************************
// Register offsets within a bank
// ****************************************
`define MMD_OFF_INDIRECT    7'h00
`define MMD_OFF_TIMER_ZERO  7'h01
`define MMD_OFF_PC_LOW      7'h02
`define MMD_OFF_STATUS      7'h03
`define MMD_OFF_POINTER     7'h04
`define MMD_OFF_PC_LATCH    7'h0a
`define MMD_OFF_INT_CTRL    7'h0b
`define MMD_OFF_RAM_START   7'h20
`define MMD_OFF_COMMON      7'h70
// ****************************************
// Fields and vectors
// ****************************************
`define MMD_STATUS_BANK_HI  6
`define MMD_STATUS_BANK_LO  5
`define MMD_RESET_VECTOR    13'h0000
`define MMD_INT_VECTOR      13'h0004
`define MMD_PC_WIDTH        13
`define MMD_RESET_BYTE      8'h00
`define MMD_RESET_STATUS    8'h18
`define MMD_RAM_WORDS       512
`define MMD_RAM_AW          9
`endif

// ==== src/mmd_ram.v ====
// Data RAM for general purpose registers, registered read.
// Assumes one clock; address settles before the edge.
`timescale 1ns/1ps
module mmd_ram #(
  parameter AW = 9,
  parameter DW = 8
) (
  // Clock
  input  wire          sys_clk,
  // Access
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ==== src/mmd_decoder.v ====
// Program address generator and banked data-memory decoder.
// Assumes a core driving fetch/data requests on sys_clk.
`timescale 1ns/1ps
`include "mmd_regs.vh"
// What this block does
// - Separate fetch and data paths, concurrent access
// - Thirteen-bit program counter, 8K space
// - Implemented program size is a parameter
// - Unimplemented high address bits simply ignored
// - Reset starts fetch at address zero
// - Interrupt loads program counter with four
// - Bank bits are status bits six, five
// - Bank pair decodes as binary bank number
// - Bank select plus 7-bit offset forms address
// - Special registers low, RAM above them
// - Mirrored special registers share one register
// - Direct address or indirect pointer access
module mmd_decoder #(
  parameter PROG_AW = 13
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Program side
  input  wire        int_take,
  input  wire        pc_load,
  input  wire [12:0] pc_load_addr,
  input  wire        pc_hold,
  output reg  [12:0] prog_addr,
  output wire [12:0] pc_value,
  // Data side
  input  wire        data_rd,
  input  wire        data_wr,
  input  wire [6:0]  data_offset,
  input  wire [7:0]  data_wdata,
  output reg  [7:0]  data_rdata,
  output reg         periph_sel,
  output reg  [8:0]  periph_addr,
  input  wire [7:0]  periph_rdata,
  output wire [7:0]  status_reg,
  output wire [7:0]  indirect_pointer,
  output wire [7:0]  program_counter_upper_latch,
  output wire [1:0]  active_bank
);
  // ****************************************
  // Core registers
  // ****************************************
  reg  [12:0] pc_q;
  reg  [12:0] pc_d;
  reg  [7:0]  status_q;
  reg  [7:0]  pointer_q;
  reg  [7:0]  latch_q;
  reg  [7:0]  int_ctrl_q;
  reg  [7:0]  timer_zero_count_q;
  reg  [7:0]  option_q;
  reg  [1:0]  rsel_q;
  reg  [7:0]  rhold_q;

  localparam [1:0] SEL_REG = 2'b01;
  localparam [1:0] SEL_RAM = 2'b10;

  // ****************************************
  // Address formation
  // ****************************************
  wire        bank_select_high = status_q[`MMD_STATUS_BANK_HI];
  wire        bank_select_low  = status_q[`MMD_STATUS_BANK_LO];
  wire        is_indirect      = (data_offset == `MMD_OFF_INDIRECT);
  // Indirect uses pointer plus the high bank bit as ninth bit
  wire [8:0]  full_addr = is_indirect ?
                {bank_select_high, pointer_q} :
                {bank_select_high, bank_select_low, data_offset};
  wire [1:0]  bank = full_addr[8:7];
  wire [6:0]  off  = full_addr[6:0];
  wire        is_ram    = (off >= `MMD_OFF_RAM_START);
  wire        is_common = (off >= `MMD_OFF_COMMON);
  // Common area folds onto bank 0
  wire [8:0]  ram_addr = is_common ? {2'b00, off} : full_addr;
  wire        core_hit = (off == `MMD_OFF_PC_LOW) ||
                         (off == `MMD_OFF_STATUS) ||
                         (off == `MMD_OFF_POINTER) ||
                         (off == `MMD_OFF_PC_LATCH) ||
                         (off == `MMD_OFF_INT_CTRL) ||
                         (off == `MMD_OFF_TIMER_ZERO) ||
                         (off == `MMD_OFF_INDIRECT);
  wire        ram_we = data_wr && is_ram;
  wire [7:0]  ram_rdata;

  mmd_ram #(
    .AW (`MMD_RAM_AW),
    .DW (8)
  ) u_ram (
    .sys_clk (sys_clk),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (data_wdata),
    .rdata   (ram_rdata)
  );

  // ****************************************
  // Program counter
  // ****************************************
  // Upper bits above the implemented size are dropped, so fetch wraps
  localparam [12:0] PROG_MASK = 13'h1fff >> (13 - PROG_AW);
  wire pcl_wr = data_wr && !is_ram && (off == `MMD_OFF_PC_LOW);

  always @* begin
    pc_d = pc_q;
    if (int_take) begin
      pc_d = `MMD_INT_VECTOR;
    end else if (pc_load) begin
      pc_d = pc_load_addr;
    end else if (pcl_wr) begin
      pc_d = {latch_q[4:0], data_wdata};
    end else if (!pc_hold) begin
      pc_d = pc_q + 13'h0001;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_q      <= `MMD_RESET_VECTOR;
      prog_addr <= `MMD_RESET_VECTOR;
    end else begin
      pc_q      <= pc_d;
      prog_addr <= pc_d & PROG_MASK;
    end
  end

  // ****************************************
  // Special register writes
  // ****************************************
  // Writes land on one physical register whatever the bank, except offset 0x01 (timer or option by bank)
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q           <= `MMD_RESET_STATUS;
      pointer_q          <= `MMD_RESET_BYTE;
      latch_q            <= `MMD_RESET_BYTE;
      int_ctrl_q         <= `MMD_RESET_BYTE;
      timer_zero_count_q <= `MMD_RESET_BYTE;
      option_q           <= 8'hff;
    end else if (data_wr && !is_ram) begin
      case (off)
        `MMD_OFF_STATUS:   status_q   <= data_wdata;
        `MMD_OFF_POINTER:  pointer_q  <= data_wdata;
        `MMD_OFF_PC_LATCH: latch_q    <= data_wdata;
        `MMD_OFF_INT_CTRL: int_ctrl_q <= data_wdata;
        `MMD_OFF_TIMER_ZERO: begin
          // Banks 0/2 hit the timer, banks 1/3 the option register
          if (bank[0]) begin
            option_q <= data_wdata;
          end else begin
            timer_zero_count_q <= data_wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // RAM read is registered, so core registers are held to match
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rsel_q      <= 2'b00;
      rhold_q     <= `MMD_RESET_BYTE;
      periph_sel  <= 1'b0;
      periph_addr <= 9'h000;
    end else begin
      rsel_q      <= 2'b00;
      periph_sel  <= 1'b0;
      periph_addr <= full_addr;
      if (data_rd) begin
        if (is_ram) begin
          rsel_q <= SEL_RAM;
        end else if (core_hit) begin
          rsel_q <= SEL_REG;
        end else begin
          periph_sel <= 1'b1;
        end
      end
      case (off)
        `MMD_OFF_PC_LOW:   rhold_q <= pc_q[7:0];
        `MMD_OFF_STATUS:   rhold_q <= status_q;
        `MMD_OFF_POINTER:  rhold_q <= pointer_q;
        `MMD_OFF_PC_LATCH: rhold_q <= latch_q;
        `MMD_OFF_INT_CTRL: rhold_q <= int_ctrl_q;
        `MMD_OFF_TIMER_ZERO:
          rhold_q <= bank[0] ? option_q : timer_zero_count_q;
        default:           rhold_q <= `MMD_RESET_BYTE;
      endcase
    end
  end

  always @* begin
    case (rsel_q)
      SEL_RAM: data_rdata = ram_rdata;
      SEL_REG: data_rdata = rhold_q;
      default: data_rdata = periph_rdata;
    endcase
  end

  // Fetch path is separate from data path so both move each cycle
  assign pc_value                    = pc_q;
  assign status_reg                  = status_q;
  assign indirect_pointer            = pointer_q;
  assign program_counter_upper_latch = latch_q;
  assign active_bank                 = {bank_select_high, bank_select_low};
endmodule

// ==== verif/mmd_periph_model.sv ====
// Peripheral stand-in answering unhandled special registers.
// Assumes the decoder's registered select and address.
`timescale 1ns/1ps
module mmd_periph_model (
  // From decoder
  input  wire       periph_sel,
  input  wire [8:0] periph_addr,
  // To decoder
  output wire [7:0] periph_rdata
);
  // Inverted pattern when idle so stale data never matches
  assign periph_rdata = periph_sel ? periph_addr[7:0] ^ 8'hc3
                                   : ~(periph_addr[7:0] ^ 8'hc3);
endmodule

// ==== verif/mmd_decoder_assertions.sv ====
// Port checker for the program and data decoder.
// Assumes bind onto mmd_decoder; one clock, sync reset.
`timescale 1ns/1ps
module mmd_checker #(
  parameter PROG_AW = 13
) (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        int_take,
  input wire        pc_load,
  input wire [12:0] pc_load_addr,
  input wire        pc_hold,
  input wire [12:0] prog_addr,
  input wire [12:0] pc_value,
  input wire        data_rd,
  input wire        data_wr,
  input wire [6:0]  data_offset,
  input wire [7:0]  data_wdata,
  input wire [7:0]  status_reg,
  input wire [7:0]  indirect_pointer,
  input wire [1:0]  active_bank
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire       quiet   = !int_take && !pc_load && !data_wr;
  wire [1:0] wr_bank = data_wdata[6:5];
  a_reset_fetch: assert property ($rose(rst_n) |-> prog_addr == 13'h0000)
    else $error("fetch not at zero after reset");
  a_int_vector: assert property (int_take |=> pc_value == 13'h0004)
    else $error("interrupt vector wrong");
  a_branch_load: assert property (pc_load && !int_take
    |=> pc_value == $past(pc_load_addr)) else $error("branch not taken");
  a_pc_step: assert property (quiet && !pc_hold
    |=> pc_value == $past(pc_value) + 13'h0001) else $error("no increment");
  a_pc_hold: assert property (quiet && pc_hold |=> $stable(pc_value))
    else $error("pc moved while held");
  a_fetch_wrap: assert property (
    prog_addr == (pc_value & ~(13'h1fff << PROG_AW)))
    else $error("fetch address not wrapped");
  a_bank_bits: assert property (active_bank == status_reg[6:5])
    else $error("bank not from status");
  a_bank_write: assert property (data_wr && data_offset == 7'h03
    |=> active_bank == $past(wr_bank)) else $error("bank write lost");
  a_pointer_write: assert property (data_wr && data_offset == 7'h04
    |=> indirect_pointer == $past(data_wdata)) else $error("pointer lost");
  c_interrupt: cover property (int_take);
  c_indirect: cover property (data_wr && data_offset == 7'h00);
  c_common: cover property (data_rd && data_offset >= 7'h70);
endmodule
bind mmd_decoder mmd_checker #(.PROG_AW(PROG_AW)) i_mmd_checker (.*);

// ==== verif/memory_map_bank_decoder_tb_top.sv ====
// Self-checking bench for the decoder, 4K program variant.
// Assumes the peripheral model and bound checker.
`timescale 1ns/1ps
module memory_map_bank_decoder_tb_top;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         int_take = 1'b0;
  reg         pc_load = 1'b0;
  reg         pc_hold = 1'b0;
  reg         data_rd = 1'b0;
  reg         data_wr = 1'b0;
  reg  [12:0] pc_load_addr = 13'h0000;
  reg  [6:0]  data_offset = 7'h00;
  reg  [7:0]  data_wdata = 8'h00;
  wire [12:0] prog_addr, pc_value;
  wire [7:0]  data_rdata, periph_rdata, status_reg, indirect_pointer, latch;
  wire        periph_sel;
  wire [8:0]  periph_addr;
  wire [1:0]  active_bank;
  integer     fail_count = 0;
  integer     checked = 0;
  always #4 sys_clk = ~sys_clk;
  mmd_decoder #(.PROG_AW(12)) i_mmd_decoder (.sys_clk, .rst_n, .int_take,
    .pc_load, .pc_load_addr, .pc_hold, .prog_addr, .pc_value, .data_rd,
    .data_wr, .data_offset, .data_wdata, .data_rdata, .periph_sel,
    .periph_addr, .periph_rdata, .status_reg, .indirect_pointer,
    .program_counter_upper_latch(latch), .active_bank);
  mmd_periph_model i_mmd_periph_model (.periph_sel, .periph_addr,
    .periph_rdata);
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string what, input [12:0] exp, input [12:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input [6:0] off, input [7:0] d);
    @(negedge sys_clk);
    data_wr = 1'b1;
    data_offset = off;
    data_wdata = d;
    @(negedge sys_clk);
    data_wr = 1'b0;
  endtask
  task rd(input [6:0] off, input [7:0] exp);
    @(negedge sys_clk);
    data_rd = 1'b1;
    data_offset = off;
    @(negedge sys_clk);
    data_rd = 1'b0;
    chk("data_rdata", {5'h00, exp}, {5'h00, data_rdata});
  endtask
  task bank(input [1:0] b);
    wr(7'h03, {1'b0, b, 5'h00});
  endtask
  task report_and_stop;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_vectors;
    @(negedge sys_clk);
    int_take = 1'b1;
    pc_load = 1'b1;
    pc_load_addr = 13'h1ffe;
    @(negedge sys_clk);
    int_take = 1'b0;
    chk("int vector", 13'h0004, pc_value);
    @(negedge sys_clk);
    pc_load = 1'b0;
    pc_hold = 1'b1;
    chk("wrapped fetch", 13'h0ffe, prog_addr);
    repeat (3) @(negedge sys_clk);
    chk("held pc", 13'h1ffe, pc_value);
    pc_hold = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("fetch after wrap", 13'h0001, prog_addr);
  endtask
  task t_banks;
    for (int b = 0; b < 4; b++) begin
      bank(2'(b));
      chk("active_bank", 13'(b), {11'h000, active_bank});
      wr(7'h20, 8'ha0 + 8'(b));
      wr(7'h70 + 7'(b), 8'h50 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      bank(2'(b));
      rd(7'h20, 8'ha0 + 8'(b));
      rd(7'h73 - 7'(b), 8'h53 - 8'(b));
    end
  endtask
  task t_mirrors;
    // Bank 3 offset 0x01 reads the option register, still at its reset value
    bank(2'd3);
    rd(7'h01, 8'hff);
    wr(7'h0b, 8'h81);
    wr(7'h01, 8'h22);
    wr(7'h04, 8'h2a);
    wr(7'h00, 8'h3c);
    wr(7'h0a, 8'h15);
    bank(2'd1);
    rd(7'h01, 8'h22);
    rd(7'h0a, 8'h15);
    rd(7'h0b, 8'h81);
    rd(7'h06, 8'h45);
    chk("periph_sel", 13'h0001, {12'h000, periph_sel});
    // Indirect write used the high bank bit, so the byte sits in bank 2
    bank(2'd2);
    rd(7'h2a, 8'h3c);
    rd(7'h01, 8'h00);
  endtask
  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    chk("reset fetch", 13'h0000, prog_addr);
    chk("status", 13'h0018, {5'h00, status_reg});
    rst_n = 1'b1;
    t_vectors;
    t_banks;
    t_mirrors;
    report_and_stop;
  end
endmodule
